/* File: verilog/lsbot_timer.sv */
// Top of the LED sink blink off-time timer: registers, shared tick, four sequencers.
// Assumes a same-clock register master: one-cycle strobes, read data one cycle later.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - One register holds four 2-bit off-time fields, sink 4 high to sink 1 low.
// - Off-time 00 keeps an enabled sink steadily on, no blinking.
// - Nonzero off-time: sink goes off for that period, then on, repeating while enabled.
// - Off-time codes 01, 10, 11 select 0.6, 1.2, 1.8 seconds.
// - Sinks enabled in one write start their sequences together.
// - Shared on-time codes give 0.2, 0.6, 0.8, 1.2 s, then off if blinking.
// - Each sink is gated by its enable bit regardless of timing state.
module lsbot_timer
  import lsbot_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DOC  // Clock cycles per 0.2 s tick
)(
  input wire logic REF_CLK,               // 25 MHz clock
  input wire logic RST,                   // Synchronous reset, high
  input wire logic CE,                    // Clock enable, freezes all state when low
  input wire logic [ADDR_W-1:0] ADDR,     // Register address
  input wire logic [DATA_W-1:0] WDATA,    // Write data
  input wire logic WR,                    // Write strobe
  input wire logic RD,                    // Read strobe
  output logic [DATA_W-1:0] RDATA,        // Read data, cycle after RD
  output logic [NSINK-1:0] SINK_ON        // Sink drive, bit 0 is sink 1
);

  localparam int PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  logic [NSINK-1:0] en_q;
  logic [1:0] on_sel_q;
  logic [DATA_W-1:0] off_q;
  logic [NSINK-1:0] restart_q;
  logic [PRE_W-1:0] pre_q;
  logic tick;
  logic [NSINK-1:0] newly_on;
  logic wr_enable;
  logic [NSINK-1:0] lit;

  assign wr_enable = WR && (ADDR == ADDR_ENABLE);
  assign newly_on = WDATA[NSINK-1:0] & ~en_q;
  assign tick = (pre_q == PRE_LAST);

  // Enable register
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      en_q <= ENABLE_RESET[NSINK-1:0];
    end else if (CE && wr_enable) begin
      en_q <= WDATA[NSINK-1:0];
    end
  end

  // Shared on-time field
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      on_sel_q <= ON_TIME_RESET;
    end else if (CE && WR && ADDR == ADDR_ON_TIME) begin
      on_sel_q <= WDATA[ON_FIELD_LSB +: FIELD_W];
    end
  end

  // Off-time fields
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      off_q <= OFF_TIMES_RESET;
    end else if (CE && WR && ADDR == ADDR_OFF_TIMES) begin
      off_q <= WDATA;
    end
  end

  // Common start for all sinks switched on by the same write
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      restart_q <= '0;
    end else if (CE) begin
      restart_q <= wr_enable ? newly_on : '0;
    end
  end

  // Shared timebase, realigned at each common start
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pre_q <= '0;
    end else if (CE) begin
      if ((wr_enable && newly_on != '0) || tick) begin
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end

  for (genvar i = 0; i < NSINK; i++) begin : g_sink
    lsbot_sink_if sif ();
    assign sif.en = en_q[i];
    assign sif.restart = restart_q[i];
    assign sif.tick = tick;
    assign sif.on_sel = on_sel_q;
    assign sif.off_sel = off_q[FIELD_W*i +: FIELD_W];
    assign lit[i] = sif.lit;
    lsbot_sink u_sink (
      .clk (REF_CLK),
      .rst (RST),
      .ce  (CE),
      .bus (sif.sink)
    );
  end

  // Registered sink drive
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      SINK_ON <= '0;
    end else if (CE) begin
      SINK_ON <= lit;
    end
  end

  // Read port; unmapped addresses return zero
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RDATA <= '0;
    end else if (CE) begin
      if (RD) begin
        unique case (ADDR)
          ADDR_ENABLE: RDATA <= {{(DATA_W-NSINK){1'b0}}, en_q};
          ADDR_ON_TIME: RDATA <= {on_sel_q, {ON_FIELD_LSB{1'b0}}};
          ADDR_OFF_TIMES: RDATA <= off_q;
          ADDR_STATUS: RDATA <= {{(DATA_W-NSINK){1'b0}}, SINK_ON};
          default: RDATA <= '0;
        endcase
      end else begin
        RDATA <= '0;
      end
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_store;
    CE && WR && ADDR == ADDR_OFF_TIMES ##1 CE && RD && ADDR == ADDR_OFF_TIMES
      |=> RDATA == $past(WDATA, 2);
  endproperty
  a_store: assert property (p_store) else $error("off-time readback wrong");

  property p_steady;
    CE && en_q[0] && off_q[1:0] == OFF_DISABLED ##1 CE && en_q[0] &&
      off_q[1:0] == OFF_DISABLED |-> SINK_ON[0] ##1 SINK_ON[0] || !CE;
  endproperty
  a_steady: assert property (p_steady) else $error("steady sink went dark");

  property p_gate;
    CE && !en_q[1] |=> !SINK_ON[1];
  endproperty
  a_gate: assert property (p_gate) else $error("disabled sink lit");

  property p_sync_start;
    CE && wr_enable && newly_on != '0 |=> pre_q == '0 && restart_q == $past(newly_on);
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("common start missed");

  property p_tick_period;
    CE && tick |=> pre_q == '0 ##0 !tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("timebase did not wrap");

  property p_status;
    CE && RD && ADDR == ADDR_STATUS |=> RDATA[NSINK-1:0] == $past(SINK_ON);
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  c_two_start: cover property (CE && wr_enable && newly_on == 4'h3);
  c_blink_dark: cover property (en_q[0] && !SINK_ON[0]);
  c_status_rd: cover property (CE && RD && ADDR == ADDR_STATUS);

endmodule
`default_nettype wire

/* File: verilog/lsbot_pkg.sv */
// Constants, register map and types of the LED sink blink off-time timer.
// Assumes a single 25 MHz clock; all blink times are whole multiples of one 0.2 s tick.
package lsbot_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 200;
  // Cycles in one tick, from the tick time and the clock rate
  localparam int TICK_CYCLES_DOC = (CLK_HZ / 1000) * TICK_MS;

  localparam int NSINK = 4;
  localparam int FIELD_W = 2;
  localparam int CNT_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] ADDR_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_ON_TIME = 8'h11;
  localparam logic [7:0] ADDR_OFF_TIMES = 8'h12;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  localparam int ON_FIELD_LSB = 6;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [1:0] ON_TIME_RESET = 2'h0;
  localparam logic [7:0] OFF_TIMES_RESET = 8'h00;
  localparam logic [1:0] OFF_DISABLED = 2'h0;

  // Period times in milliseconds, indexed by field code
  localparam int ON_MS [4] = '{200, 600, 800, 1200};
  localparam int OFF_MS [4] = '{0, 600, 1200, 1800};

  function automatic logic [CNT_W-1:0] ms_to_ticks(input int ms);
    return CNT_W'(ms / TICK_MS);
  endfunction

  typedef enum logic [1:0] {PH_IDLE, PH_ON, PH_OFF} lsbot_phase_t;

endpackage

/* File: verilog/lsbot_sink_if.sv */
// Link between the register/timebase logic and one sink blink sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface lsbot_sink_if;
  logic en;
  logic restart;
  logic tick;
  logic [1:0] on_sel;
  logic [1:0] off_sel;
  logic lit;
  modport ctrl (output en, output restart, output tick, output on_sel, output off_sel,
                input lit);
  modport sink (input en, input restart, input tick, input on_sel, input off_sel,
                output lit);
endinterface
`default_nettype wire

/* File: verilog/lsbot_sink.sv */
// Blink sequencer for one sink: on period, off period, repeat.
// Assumes tick is a one-cycle pulse every 0.2 s and restart a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module lsbot_sink
  import lsbot_pkg::*;
(
  input wire logic clk,    // Clock
  input wire logic rst,    // Synchronous reset, high
  input wire logic ce,     // Clock enable
  lsbot_sink_if.sink bus   // Control and lit state
);

  lsbot_phase_t phase_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] on_ticks;
  logic [CNT_W-1:0] off_ticks;
  logic [CNT_W-1:0] cnt_inc;
  logic blinking;

  assign on_ticks = ms_to_ticks(ON_MS[bus.on_sel]);
  assign off_ticks = ms_to_ticks(OFF_MS[bus.off_sel]);
  assign cnt_inc = cnt_q + 1'b1;
  assign blinking = (bus.off_sel != OFF_DISABLED);

  // Lit unless in the off period of a blinking sink; a cleared enable always darkens
  assign bus.lit = bus.en && (!blinking || phase_q != PH_OFF);

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= PH_IDLE;
      cnt_q <= '0;
    end else if (ce) begin
      if (!bus.en) begin
        phase_q <= PH_IDLE;
        cnt_q <= '0;
      end else if (bus.restart || phase_q == PH_IDLE) begin
        phase_q <= PH_ON;
        cnt_q <= '0;
      end else begin
        unique case (phase_q)
          PH_ON: begin
            if (!blinking) begin
              cnt_q <= '0;
            end else if (bus.tick) begin
              if (cnt_inc >= on_ticks) begin
                phase_q <= PH_OFF;
                cnt_q <= '0;
              end else begin
                cnt_q <= cnt_inc;
              end
            end
          end
          PH_OFF: begin
            if (!blinking) begin
              phase_q <= PH_ON;
              cnt_q <= '0;
            end else if (bus.tick) begin
              if (cnt_inc >= off_ticks) begin
                phase_q <= PH_ON;
                cnt_q <= '0;
              end else begin
                cnt_q <= cnt_inc;
              end
            end
          end
          default: begin
            phase_q <= PH_IDLE;
            cnt_q <= '0;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_off_to_on;
    ce && bus.en && !bus.restart && phase_q == PH_OFF && blinking && bus.tick &&
      cnt_inc >= off_ticks |=> phase_q == PH_ON && cnt_q == '0;
  endproperty
  a_off_to_on: assert property (p_off_to_on) else $error("off period did not end");

  property p_off_decode;
    blinking |-> off_ticks == CNT_W'(3) * CNT_W'(bus.off_sel);
  endproperty
  a_off_decode: assert property (p_off_decode) else $error("off time decode wrong");

  property p_on_to_off;
    ce && bus.en && !bus.restart && phase_q == PH_ON && blinking && bus.tick &&
      cnt_inc >= on_ticks |=> phase_q == PH_OFF ##0 (!bus.lit || !bus.en || !blinking);
  endproperty
  a_on_to_off: assert property (p_on_to_off) else $error("on period did not end");

  property p_on_decode;
    (bus.on_sel == 2'h0 |-> on_ticks == 4'h1) and (bus.on_sel == 2'h2 |-> on_ticks == 4'h4);
  endproperty
  a_on_decode: assert property (p_on_decode) else $error("on time decode wrong");

  property p_cnt_hold;
    ce && bus.en && !bus.restart && phase_q != PH_IDLE && !bus.tick && blinking &&
      $stable(bus.off_sel) |=> $stable(cnt_q);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without tick");

  c_enter_off: cover property (phase_q == PH_ON ##1 phase_q == PH_OFF);
  c_full_cycle: cover property (phase_q == PH_OFF ##1 phase_q == PH_ON);

endmodule
`default_nettype wire

/* File: dv/lsbot_timer_test.sv */
// Self-checking bench for the LED sink blink off-time timer.
// Assumes the design top lsbot_timer with a short tick so blink runs stay brief.
`timescale 1ns/1ps
`default_nettype none
module lsbot_timer_test;
  import lsbot_pkg::*;
  localparam int T = 10;
  logic REF_CLK, RST, CE, WR, RD;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA, RDATA;
  logic [NSINK-1:0] SINK_ON;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h897f;

  lsbot_timer #(.TICK_CYCLES(T)) i_lsbot_timer (.REF_CLK(REF_CLK), .RST(RST), .CE(CE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SINK_ON(SINK_ON));

  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Expected run lengths in clock cycles
  function automatic int on_len(input logic [1:0] c);
    return ON_MS[c] / TICK_MS * T;
  endfunction
  function automatic int off_len(input logic [1:0] c);
    return OFF_MS[c] / TICK_MS * T;
  endfunction

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    @(negedge REF_CLK);
    chk(name, {8'h00, exp}, {8'h00, RDATA});
  endtask

  // Write then read straight after it, no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    @(negedge REF_CLK);
    chk("back to back", {8'h00, d}, {8'h00, RDATA});
    @(negedge REF_CLK);
    chk("read data idle", 16'h0000, {8'h00, RDATA});
  endtask

  // Sink i gets off code (i + on code) mod 4, so one sink is steady each round
  task automatic blink_round(input logic [1:0] on_c);
    logic [7:0] offw;
    logic [3:0] bm, prev, s;
    int cnt [4];
    int k;
    begin
      offw = 8'h00;
      bm = 4'h0;
      for (int i = 0; i < 4; i++) begin
        offw[2*i +: 2] = 2'(i + on_c);
        bm[i] = (offw[2*i +: 2] != OFF_DISABLED);
      end
      wr(ADDR_ENABLE, 8'h00);
      wr(ADDR_ON_TIME, {on_c, 6'h00});
      wr(ADDR_OFF_TIMES, offw);
      rd(ADDR_OFF_TIMES, offw, "off times");
      wr(ADDR_ENABLE, 8'h0f);
      @(negedge REF_CLK);
      @(negedge REF_CLK);
      chk("all lit", 16'h000f, {12'h000, SINK_ON});
      k = 0;
      while ((SINK_ON & bm) == bm && k < 200) begin
        @(negedge REF_CLK);
        k++;
      end
      chk("first off", {12'h000, ~bm}, {12'h000, SINK_ON});
      prev = SINK_ON;
      cnt = '{1, 1, 1, 1};
      for (k = 0; k < 300; k++) begin
        @(negedge REF_CLK);
        s = SINK_ON;
        for (int i = 0; i < 4; i++) begin
          if (s[i] !== prev[i]) begin
            if (prev[i]) chk("on run", 16'(on_len(on_c)), 16'(cnt[i]));
            else chk("off run", 16'(off_len(offw[2*i +: 2])), 16'(cnt[i]));
            cnt[i] = 1;
          end else begin
            cnt[i]++;
          end
        end
        prev = s;
      end
      chk("steady sink", {12'h000, ~bm}, {12'h000, SINK_ON & ~bm});
      wr(ADDR_ENABLE, 8'h0f & ~(8'h01 << on_c));
      @(negedge REF_CLK);
      @(negedge REF_CLK);
      chk("disabled sink", 16'h0000, {15'h0000, SINK_ON[on_c]});
      $display("test blink round %0d done", on_c);
    end
  endtask

  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 10000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    logic [3:0] held;
    RST = 1'b1;
    CE = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    rd(ADDR_ENABLE, ENABLE_RESET, "enable reset");
    rd(ADDR_ON_TIME, {ON_TIME_RESET, 6'h00}, "on time reset");
    rd(ADDR_OFF_TIMES, OFF_TIMES_RESET, "off times reset");
    rd(ADDR_STATUS, 8'h00, "status reset");
    chk("sinks after reset", 16'h0000, {12'h000, SINK_ON});
    $display("test reset done");
    for (int n = 0; n < 8; n++) begin
      seed = xs(seed);
      wr(ADDR_OFF_TIMES, seed[7:0]);
      wr(8'h33, seed[15:8]);
      rd(ADDR_OFF_TIMES, seed[7:0], "off times");
      wr(ADDR_ON_TIME, seed[23:16]);
      rd(ADDR_ON_TIME, seed[23:16] & 8'hc0, "on time");
      rd(8'h33, 8'h00, "unmapped");
      wr_rd(ADDR_OFF_TIMES, seed[31:24]);
    end
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      blink_round(2'(r));
    end
    // Frozen state: outputs hold and a write is not taken while CE is low
    wr(ADDR_ENABLE, 8'h0f);
    repeat (17) @(posedge REF_CLK);
    CE <= 1'b0;
    @(negedge REF_CLK);
    held = SINK_ON;
    wr(ADDR_OFF_TIMES, 8'h00);
    repeat (30) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk("frozen sinks", {12'h000, held}, {12'h000, SINK_ON});
    @(posedge REF_CLK);
    CE <= 1'b1;
    rd(ADDR_OFF_TIMES, 8'h93, "off times after freeze");
    // Sink 2 has off code 00 here, so it alone stays lit
    wr(ADDR_ENABLE, 8'h02);
    rd(ADDR_STATUS, 8'h02, "status steady");
    $display("test freeze done");
    stop_test();
  end
endmodule
`default_nettype wire
